// [hw/cfg_pins_pkg.sv]
// Package: constants, modes, register map and carriers for the config pin block
// Notes on behaviour
// - Config clock drives in master/async peripheral
// - After done, config clock clocks readback
// - Any clock phase length accepted outside readback
// - Completion pin driven low until finished, then released
// - External low on completion delays startup
// - Low clear request clears configuration memory
// - On release: finish pass, one more, wait
// - Byte-accept status shown in peripheral modes
// - Async peripheral read shows status on data_msb
// - Address strobe rises before each address change
// - Mode pins sampled after clear-complete rises
// - After config only mode pin 1 becomes a plain user pin
// - Test data out from scan, else user
// - Three-bit mode code decode
// - Master clock starts 1 MHz, may go 10
// - Parallel address starts zero or top
// - Slave serial: rise capture, fall forward
package cfg_pins_pkg;

  typedef enum logic [2:0] {
    MODE_MSER  = 3'h0,
    MODE_RSV1  = 3'h1,
    MODE_RSV2  = 3'h2,
    MODE_SPER  = 3'h3,
    MODE_MPUP  = 3'h4,
    MODE_APER  = 3'h5,
    MODE_MPDN  = 3'h6,
    MODE_SSER  = 3'h7
  } cfg_mode_t;

  typedef enum logic [2:0] {
    ST_CLEAR   = 3'h0,
    ST_FINAL   = 3'h1,
    ST_WAIT    = 3'h2,
    ST_LOAD    = 3'h3,
    ST_HOLD    = 3'h4,
    ST_USER    = 3'h5
  } cfg_state_t;

  localparam logic [7:0]  ADDR_CTRL    = 8'h00;
  localparam logic [7:0]  ADDR_STATUS  = 8'h04;
  localparam logic [7:0]  ADDR_IRQ_ST  = 8'h08;
  localparam logic [7:0]  ADDR_IRQ_EN  = 8'h0C;
  localparam logic [7:0]  ADDR_IRQ_CLR = 8'h10;
  localparam logic [7:0]  ADDR_DATA    = 8'h14;
  localparam logic [7:0]  ADDR_LENGTH  = 8'h18;

  localparam int          CTRL_FAST    = 0;
  localparam int          CTRL_WDONE   = 1;
  localparam int          CTRL_SCAN    = 2;
  localparam int          CTRL_M1OUT   = 3;
  localparam int          CTRL_M1OE    = 4;
  localparam int          CTRL_TDOUT   = 5;
  localparam int          CTRL_TDOE    = 6;

  localparam int          IRQ_CLR_DONE = 0;
  localparam int          IRQ_DONE     = 1;
  localparam int          IRQ_BYTE     = 2;
  localparam int          IRQ_BADMODE  = 3;

  localparam int          CLK_HZ       = 20000000;
  localparam int          SLOW_HZ      = 1000000;
  localparam int          FAST_HZ      = 8000000;
  localparam logic [4:0]  SLOW_HALF    = 5'(CLK_HZ / SLOW_HZ / 2);
  localparam logic [4:0]  FAST_HALF    = 5'((CLK_HZ / FAST_HZ) / 2);
  localparam logic [9:0]  CLEAR_WORDS  = 10'h040;
  localparam logic [21:0] ADDR_TOP     = 22'h03FFFF;
  localparam logic [15:0] LEN_RESET    = 16'h0010;

  typedef struct packed {
    logic       out;
    logic       oe;
  } pin_drive_t;

  typedef struct packed {
    logic [7:0] adr;
    logic [31:0] dat;
    logic [3:0] sel;
    logic       we;
    logic       stb;
    logic       cyc;
  } wb_req_t;

endpackage : cfg_pins_pkg

// [hw/pin_sync.sv]
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] async_i,
  input  wire logic [W-1:0] rst_val_i,
  output logic      [W-1:0] sync_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_state_t;

  sync_state_t st_q;
  sync_state_t st_d;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = async_i;
    st_d.s2 = st_q.s1;
  end

  // Reset value is a tied constant from the parent
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= {rst_val_i, rst_val_i};
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_o = st_q.s2;
endmodule // pin_sync
`default_nettype wire

// [hw/cfg_pins.sv]
// Configuration control pin logic with Wishbone register access
//
// The Wishbone register port and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module cfg_pins (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_cyc_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq_o,
  input  wire logic        clear_req_n_i,
  input  wire logic        done_i,
  output logic             done_o,
  output logic             done_oe_o,
  input  wire logic        config_clock_i,
  output logic             config_clock_o,
  output logic             config_clock_oe_o,
  output logic             clear_done_n_o,
  input  wire logic        mode_select_0_i,
  input  wire logic        mode_select_1_i,
  input  wire logic        mode_select_2_i,
  output logic             mode_select_1_o,
  output logic             mode_select_1_oe_o,
  input  wire logic        din_i,
  output logic             dout_o,
  input  wire logic [7:0]  pdata_i,
  input  wire logic        host_sel_i,
  input  wire logic        host_wr_n_i,
  input  wire logic        host_rd_n_i,
  output logic             data_msb_o,
  output logic             data_msb_oe_o,
  output logic             byte_ready_o,
  output logic [21:0]      prom_addr_o,
  output logic             addr_strobe_o,
  input  wire logic        scan_tdo_i,
  output logic             tdo_o,
  output logic             tdo_oe_o,
  output logic             startup_o,
  output logic             readback_clk_en_o
);
  typedef struct packed {
    cfg_pins_pkg::cfg_state_t state;
    cfg_pins_pkg::cfg_mode_t  mode;
    logic [9:0]               clr_cnt;
    logic [15:0]              bits_left;
    logic [4:0]               div;
    logic                     clk_out;
    logic                     fast;
    logic [7:0]               shreg;
    logic [3:0]               shcnt;
    logic                     busy;
    logic [21:0]              addr;
    logic                     strobe;
    logic                     adv_pend;
    logic                     cc_prev;
    logic                     wr_prev;
    logic                     dout;
    logic [6:0]               ctrl;
    logic [15:0]              length;
    logic [3:0]               irq_st;
    logic [3:0]               irq_en;
    logic                     ack;
    logic [31:0]              rdat;
    logic                     irq;
    logic                     done;
    logic                     msb_oe;
    logic                     fwd;
    logic                     strobe_seen;
    logic                     done_oe;
    logic                     clk_oe;
    logic                     clr_done_n;
    logic                     ready;
  } top_state_t;

  top_state_t st_q;
  top_state_t st_d;

  logic [8:0] pin_s;
  logic       clr_n_s;
  logic       done_s;
  logic       cc_s;
  logic       din_s;
  logic       wr_n_s;
  logic       rd_n_s;
  logic       sel_s;
  logic       ms0_s;
  logic       ms1_s;
  logic       ms2_s;

  pin_sync #(.W(9)) u_sync (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .async_i   ({clear_req_n_i, done_i, config_clock_i, din_i, host_wr_n_i,
                 host_rd_n_i, mode_select_0_i, mode_select_1_i, mode_select_2_i}),
    .rst_val_i (9'h1FF),
    .sync_o    (pin_s)
  );
  assign {clr_n_s, done_s, cc_s, din_s, wr_n_s, rd_n_s, ms0_s, ms1_s, ms2_s} = pin_s;

  logic sel_q1;
  logic sel_q2;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_q1 <= 1'b0;
      sel_q2 <= 1'b0;
    end else begin
      sel_q1 <= host_sel_i;
      sel_q2 <= sel_q1;
    end
  end
  assign sel_s = sel_q2;

  logic       master_clk;
  logic       cc_rise;
  logic       cc_fall;
  logic       wr_pulse;
  logic       wb_hit;
  logic [31:0] status_w;
  logic [3:0] ev;

  always_comb begin
    top_state_t n;
    n = st_q;
    // Master serial, both master parallel and async peripheral drive the clock
    master_clk = (st_q.mode == cfg_pins_pkg::MODE_MSER) || (st_q.mode == cfg_pins_pkg::MODE_MPUP)
              || (st_q.mode == cfg_pins_pkg::MODE_MPDN) || (st_q.mode == cfg_pins_pkg::MODE_APER);
    // Edges of the link clock, either own divider or sampled pin
    cc_rise  = master_clk ? (st_q.clk_out && !st_q.cc_prev) : (cc_s && !st_q.cc_prev);
    cc_fall  = master_clk ? (!st_q.clk_out && st_q.cc_prev) : (!cc_s && st_q.cc_prev);
    n.cc_prev = master_clk ? st_q.clk_out : cc_s;
    wr_pulse = st_q.wr_prev && !wr_n_s && sel_s;
    n.wr_prev = wr_n_s;
    ev = 4'h0;

    // Clock divider for the driven clock; only edges matter, so phases may stretch
    if (st_q.state == cfg_pins_pkg::ST_LOAD && master_clk &&
        !(st_q.mode == cfg_pins_pkg::MODE_APER && !st_q.busy)) begin
      if (st_q.div == 5'h00) begin
        n.div     = (st_q.fast ? cfg_pins_pkg::FAST_HALF : cfg_pins_pkg::SLOW_HALF) - 5'h01;
        n.clk_out = !st_q.clk_out;
      end else begin
        n.div = st_q.div - 5'h01;
      end
    end

    n.strobe = 1'b0;
    case (st_q.state)
      cfg_pins_pkg::ST_CLEAR: begin
        n.clr_cnt = st_q.clr_cnt + 10'h001;
        if (st_q.clr_cnt == cfg_pins_pkg::CLEAR_WORDS - 10'h001) begin
          n.clr_cnt = 10'h000;
          if (clr_n_s) begin
            n.state = cfg_pins_pkg::ST_FINAL;
          end
        end
      end
      cfg_pins_pkg::ST_FINAL: begin
        n.clr_cnt = st_q.clr_cnt + 10'h001;
        if (st_q.clr_cnt == cfg_pins_pkg::CLEAR_WORDS - 10'h001) begin
          n.clr_cnt = 10'h000;
          n.state   = cfg_pins_pkg::ST_WAIT;
          ev[cfg_pins_pkg::IRQ_CLR_DONE] = 1'b1;
        end
      end
      cfg_pins_pkg::ST_WAIT: begin
        // Mode pins read once clear-complete is released high
        n.mode      = cfg_pins_pkg::cfg_mode_t'({ms2_s, ms1_s, ms0_s});
        n.bits_left = {st_q.length[12:0], 3'h0};
        n.fast      = 1'b0;
        n.busy      = 1'b0;
        n.shcnt     = 4'h0;
        n.div       = 5'h00;
        n.clk_out   = 1'b0;
        n.addr      = ({ms2_s, ms1_s, ms0_s} == 3'h6) ? cfg_pins_pkg::ADDR_TOP : 22'h000000;
        // First strobe must lead even the first address move
        n.adv_pend  = 1'b0;
        if ({ms2_s, ms1_s, ms0_s} == 3'h1 || {ms2_s, ms1_s, ms0_s} == 3'h2) begin
          ev[cfg_pins_pkg::IRQ_BADMODE] = 1'b1;
        end else begin
          n.state = cfg_pins_pkg::ST_LOAD;
        end
      end
      cfg_pins_pkg::ST_LOAD: begin
        if (st_q.bits_left == 16'h0000) begin
          n.state = cfg_pins_pkg::ST_HOLD;
        end else begin
          case (st_q.mode)
            cfg_pins_pkg::MODE_MSER, cfg_pins_pkg::MODE_SSER: begin
              if (cc_rise) begin
                n.bits_left = st_q.bits_left - 16'h0001;
                if (st_q.bits_left[2:0] == 3'h1) begin
                  ev[cfg_pins_pkg::IRQ_BYTE] = 1'b1;
                end
              end
            end
            cfg_pins_pkg::MODE_MPUP, cfg_pins_pkg::MODE_MPDN: begin
              // Strobe rises one edge ahead of the address change
              if (cc_fall && st_q.shcnt == 4'h0) begin
                n.strobe   = 1'b1;
                n.adv_pend = 1'b1;
              end else if (st_q.adv_pend && !st_q.strobe && cc_rise) begin
                n.adv_pend = 1'b0;
                n.shreg    = pdata_i;
                n.shcnt    = 4'h8;
                n.addr     = (st_q.mode == cfg_pins_pkg::MODE_MPUP) ?
                             st_q.addr + 22'h000001 : st_q.addr - 22'h000001;
              end
              if (cc_rise && st_q.shcnt != 4'h0) begin
                n.shcnt     = st_q.shcnt - 4'h1;
                n.bits_left = st_q.bits_left - 16'h0001;
              end
            end
            cfg_pins_pkg::MODE_SPER, cfg_pins_pkg::MODE_APER: begin
              if (wr_pulse && !st_q.busy) begin
                n.shreg = pdata_i;
                n.busy  = 1'b1;
                n.shcnt = 4'h8;
              end else if (cc_rise && st_q.busy) begin
                n.shcnt     = st_q.shcnt - 4'h1;
                n.bits_left = st_q.bits_left - 16'h0001;
                if (st_q.shcnt == 4'h1) begin
                  n.busy = 1'b0;
                  ev[cfg_pins_pkg::IRQ_BYTE] = 1'b1;
                end
              end
            end
            default: n.state = cfg_pins_pkg::ST_LOAD;
          endcase
          if (cc_rise && !st_q.fast && st_q.bits_left[3:0] == 4'h0) begin
            n.fast = st_q.ctrl[cfg_pins_pkg::CTRL_FAST];
          end
        end
      end
      cfg_pins_pkg::ST_HOLD: begin
        // Optional wait on an external low completion level
        if (!st_q.ctrl[cfg_pins_pkg::CTRL_WDONE] || done_s) begin
          n.state = cfg_pins_pkg::ST_USER;
          ev[cfg_pins_pkg::IRQ_DONE] = 1'b1;
        end
      end
      cfg_pins_pkg::ST_USER: n.state = cfg_pins_pkg::ST_USER;
      default: n.state = cfg_pins_pkg::ST_CLEAR;
    endcase
    // Strobe remembered until the address next moves
    if (st_q.strobe) begin
      n.strobe_seen = 1'b1;
    end else if (n.addr != st_q.addr) begin
      n.strobe_seen = 1'b0;
    end
    n.done = (n.state == cfg_pins_pkg::ST_HOLD) || (n.state == cfg_pins_pkg::ST_USER);

    // Surplus bit taken at a rise, shown at the next fall
    if (st_q.state == cfg_pins_pkg::ST_HOLD || st_q.state == cfg_pins_pkg::ST_USER) begin
      if (cc_rise) begin
        n.fwd = din_s;
      end
      if (cc_fall) begin
        n.dout = st_q.fwd;
      end
    end
    n.msb_oe = (st_q.mode == cfg_pins_pkg::MODE_APER) && sel_s && !rd_n_s
            && (st_q.state == cfg_pins_pkg::ST_LOAD);

    // Clear request wins over state, done and busy, restarting passes
    if (!clr_n_s) begin
      n.state   = cfg_pins_pkg::ST_CLEAR;
      n.done    = 1'b0;
      n.busy    = 1'b0;
      if (st_q.state != cfg_pins_pkg::ST_CLEAR) begin
        n.clr_cnt = 10'h000;
      end
    end
    // Pin controls registered so outputs come from flops
    n.done_oe    = !n.done;
    n.ready      = !n.busy;
    n.clr_done_n = (n.state != cfg_pins_pkg::ST_CLEAR) && (n.state != cfg_pins_pkg::ST_FINAL);
    n.clk_oe     = (n.state == cfg_pins_pkg::ST_LOAD) && (n.mode inside {cfg_pins_pkg::MODE_MSER,
                   cfg_pins_pkg::MODE_MPUP, cfg_pins_pkg::MODE_MPDN, cfg_pins_pkg::MODE_APER});

    // Wishbone slave, one wait state, ack drops after one cycle
    wb_hit = wb_cyc_i && wb_stb_i && !st_q.ack;
    n.ack  = wb_hit;
    status_w = {11'h000, st_q.busy, st_q.state, st_q.mode, st_q.fast, st_q.addr[12:0]};
    n.rdat = 32'h00000000;
    if (wb_hit && !wb_we_i) begin
      case (wb_adr_i)
        cfg_pins_pkg::ADDR_CTRL:   n.rdat = {25'h0000000, st_q.ctrl};
        cfg_pins_pkg::ADDR_STATUS: n.rdat = status_w;
        cfg_pins_pkg::ADDR_IRQ_ST: n.rdat = {28'h0000000, st_q.irq_st};
        cfg_pins_pkg::ADDR_IRQ_EN: n.rdat = {28'h0000000, st_q.irq_en};
        cfg_pins_pkg::ADDR_DATA:   n.rdat = {24'h000000, st_q.shreg};
        cfg_pins_pkg::ADDR_LENGTH: n.rdat = {16'h0000, st_q.length};
        default:                   n.rdat = 32'h00000000;
      endcase
    end
    n.irq_st = st_q.irq_st;
    if (wb_hit && wb_we_i && wb_sel_i[0]) begin
      case (wb_adr_i)
        cfg_pins_pkg::ADDR_CTRL:    n.ctrl   = wb_dat_i[6:0];
        cfg_pins_pkg::ADDR_IRQ_EN:  n.irq_en = wb_dat_i[3:0];
        cfg_pins_pkg::ADDR_IRQ_CLR: n.irq_st = st_q.irq_st & ~wb_dat_i[3:0];
        cfg_pins_pkg::ADDR_LENGTH:  n.length[7:0] = wb_dat_i[7:0];
        default:                    n.ctrl   = st_q.ctrl;
      endcase
    end
    if (wb_hit && wb_we_i && wb_sel_i[1] && wb_adr_i == cfg_pins_pkg::ADDR_LENGTH) begin
      n.length[15:8] = wb_dat_i[15:8];
    end
    // Set beats clear in the same cycle
    n.irq_st = n.irq_st | ev;
    n.irq    = |(n.irq_st & n.irq_en);
    st_d = n;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q        <= '0;
      st_q.mode   <= cfg_pins_pkg::MODE_SSER;
      st_q.length <= cfg_pins_pkg::LEN_RESET;
      st_q.wr_prev <= 1'b1;
      st_q.done_oe <= 1'b1;
      st_q.ready   <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  logic user_q;
  logic ms1_q;
  logic ms1_oe_q;
  logic tdo_q;
  logic tdo_oe_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      user_q   <= 1'b0;
      ms1_q    <= 1'b0;
      ms1_oe_q <= 1'b0;
      tdo_q    <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else begin
      user_q   <= st_d.state == cfg_pins_pkg::ST_USER;
      ms1_q    <= st_d.ctrl[cfg_pins_pkg::CTRL_M1OUT];
      ms1_oe_q <= st_d.ctrl[cfg_pins_pkg::CTRL_M1OE] && (st_d.state == cfg_pins_pkg::ST_USER);
      // Scan path takes the pin whenever enabled, otherwise user drive
      tdo_q    <= st_d.ctrl[cfg_pins_pkg::CTRL_SCAN] ? scan_tdo_i
                : st_d.ctrl[cfg_pins_pkg::CTRL_TDOUT];
      tdo_oe_q <= st_d.ctrl[cfg_pins_pkg::CTRL_SCAN] ||
                  (st_d.ctrl[cfg_pins_pkg::CTRL_TDOE] && st_d.state == cfg_pins_pkg::ST_USER);
    end
  end

  assign wb_dat_o           = st_q.rdat;
  assign wb_ack_o           = st_q.ack;
  assign irq_o              = st_q.irq;
  assign done_o             = st_q.done;
  assign done_oe_o          = st_q.done_oe;
  assign config_clock_o     = st_q.clk_out;
  assign config_clock_oe_o  = st_q.clk_oe;
  assign clear_done_n_o     = st_q.clr_done_n;
  assign mode_select_1_o    = ms1_q;
  assign mode_select_1_oe_o = ms1_oe_q;
  assign dout_o             = st_q.dout;
  assign data_msb_o         = st_q.ready;
  assign data_msb_oe_o      = st_q.msb_oe;
  assign byte_ready_o       = st_q.ready;
  assign prom_addr_o        = st_q.addr;
  assign addr_strobe_o      = st_q.strobe;
  assign tdo_o              = tdo_q;
  assign tdo_oe_o           = tdo_oe_q;
  assign startup_o          = user_q;
  // Readback may be clocked from the pin only once configured
  assign readback_clk_en_o  = user_q;

  a_clear_blocks: assert property (@(posedge clk_i) disable iff (rst_i)
    !clr_n_s |=> st_q.state == cfg_pins_pkg::ST_CLEAR && !done_o)
    else $error("clear request did not hold clear");
  a_final_pass: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(st_q.state == cfg_pins_pkg::ST_WAIT) |-> $past(st_q.state) == cfg_pins_pkg::ST_FINAL)
    else $error("wait entered without final pass");
  a_clk_dir: assert property (@(posedge clk_i) disable iff (rst_i)
    config_clock_oe_o |-> st_q.mode != cfg_pins_pkg::MODE_SSER && st_q.mode != cfg_pins_pkg::MODE_SPER)
    else $error("clock driven in input mode");
  a_done_drive: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_q.state == cfg_pins_pkg::ST_USER && clr_n_s) |=> done_o)
    else $error("done lost while configured");
  a_msb_status: assert property (@(posedge clk_i) disable iff (rst_i)
    data_msb_oe_o |-> st_q.mode == cfg_pins_pkg::MODE_APER && data_msb_o == byte_ready_o)
    else $error("msb status wrong");
  a_strobe_lead: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(prom_addr_o) && $past(st_q.state) == cfg_pins_pkg::ST_LOAD |-> $past(st_q.strobe_seen))
    else $error("address moved without strobe");
  a_reserved_mode: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q.state == cfg_pins_pkg::ST_LOAD |-> st_q.mode != cfg_pins_pkg::MODE_RSV1 && st_q.mode != cfg_pins_pkg::MODE_RSV2)
    else $error("loading in reserved mode");
  a_hold_done: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q.state == cfg_pins_pkg::ST_HOLD && st_q.ctrl[cfg_pins_pkg::CTRL_WDONE] && !done_s && clr_n_s |=> !startup_o)
    else $error("startup despite low done");
endmodule // cfg_pins
`default_nettype wire

// [verif/cfg_source.sv]
// Partner model: serial source with link clock, and a byte-wide PROM
`timescale 1ns/10ps
`default_nettype none
module cfg_source (
  input  wire logic        run_i,
  input  wire logic [21:0] prom_addr_i,
  output logic             config_clock_o,
  output logic             din_o,
  output logic [7:0]       pdata_o
);
  initial begin
    config_clock_o = 1'b0;
    din_o          = 1'b0;
  end
  // Link clock stands still outside frames; its edges fall on falling edges of clk_i
  always begin
    #200;
    if (run_i) begin
      config_clock_o = ~config_clock_o;
      if (!config_clock_o) begin
        din_o = 1'($urandom);
      end
    end else begin
      config_clock_o = 1'b0;
      din_o = ~din_o; // Idle line toggles, no stale value
    end
  end
  assign pdata_o = prom_addr_i[7:0] ^ 8'hA5;
endmodule // cfg_source
`default_nettype wire

// [verif/tb_top.sv]
// Self-checking bench for the configuration pin block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        clk_i, rst_i, wb_we_i, wb_stb_i, wb_cyc_i, clear_req_n_i, done_i, din_i;
  logic        config_clock_i, mode_select_0_i, mode_select_1_i, mode_select_2_i;
  logic        host_sel_i, host_wr_n_i, host_rd_n_i, scan_tdo_i, done_hold_n, run, b;
  logic        wb_ack_o, irq_o, done_o, done_oe_o, config_clock_o, config_clock_oe_o;
  logic        clear_done_n_o, mode_select_1_o, mode_select_1_oe_o, dout_o, data_msb_o;
  logic        data_msb_oe_o, byte_ready_o, addr_strobe_o, tdo_o, tdo_oe_o, startup_o;
  logic        readback_clk_en_o;
  logic [7:0]  wb_adr_i, pdata_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [3:0]  wb_sel_i;
  logic [21:0] prom_addr_o;
  logic [2:0]  mode_q;
  logic [2:0]  modes [8] = '{3'h1, 3'h2, 3'h0, 3'h4, 3'h6, 3'h5, 3'h3, 3'h7};
  logic [63:0] exp_q [$];
  int          bad_count, samples_checked;

  cfg_pins cfg_pins_i (
    .clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_stb_i, .wb_cyc_i,
    .wb_dat_o, .wb_ack_o, .irq_o, .clear_req_n_i, .done_i, .done_o, .done_oe_o,
    .config_clock_i, .config_clock_o, .config_clock_oe_o, .clear_done_n_o,
    .mode_select_0_i, .mode_select_1_i, .mode_select_2_i, .mode_select_1_o,
    .mode_select_1_oe_o, .din_i, .dout_o, .pdata_i, .host_sel_i, .host_wr_n_i,
    .host_rd_n_i, .data_msb_o, .data_msb_oe_o, .byte_ready_o, .prom_addr_o,
    .addr_strobe_o, .scan_tdo_i, .tdo_o, .tdo_oe_o, .startup_o, .readback_clk_en_o);
  cfg_source cfg_source_i (.run_i(run), .prom_addr_i(prom_addr_o),
    .config_clock_o(config_clock_i), .din_o(din_i), .pdata_o(pdata_i));

  assign done_i = done_hold_n & (done_oe_o ? done_o : 1'b1);
  assign mode_select_0_i = mode_q[0];
  assign mode_select_1_i = mode_select_1_oe_o ? mode_select_1_o : mode_q[1];
  assign mode_select_2_i = mode_q[2];

  function automatic logic [31:0] z(input logic v);
    return {31'h0, v};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Reads note {mask, expected}; the monitor compares at ack
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    input logic [31:0] m);
    if (!we) exp_q.push_back({m, d});
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    // Only the watchdog ends a wait for ack
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wait_lvl(ref logic s, input logic v, input int lim);
    int n;
    n = 0;
    while (s !== v && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    chk(z(s), z(v));
  endtask

  always @(posedge clk_i) begin
    logic [63:0] e;
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      chk(wb_dat_o & e[63:32], e[31:0] & e[63:32]);
    end
  end
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    give_verdict();
  end

  initial begin
    {rst_i, clear_req_n_i, done_hold_n, host_wr_n_i, host_rd_n_i} = 5'h1F;
    {wb_we_i, wb_stb_i, wb_cyc_i, run, host_sel_i, scan_tdo_i} = 6'h00;
    {wb_adr_i, wb_dat_i, wb_sel_i, mode_q} = {8'h00, 32'h0, 4'hF, 3'h7};
    void'($urandom(32'h7658));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    chk(z(byte_ready_o), 32'h1);
    wb(1'b0, cfg_pins_pkg::ADDR_LENGTH, 32'h10, 32'hFFFF);
    wb(1'b0, 8'h1C, 32'h0, 32'hFFFFFFFF); // Unmapped reads as zero
    wb(1'b1, cfg_pins_pkg::ADDR_LENGTH, 32'h2, 32'h0);
    wb(1'b1, cfg_pins_pkg::ADDR_IRQ_EN, 32'hF, 32'h0);
    wb(1'b0, cfg_pins_pkg::ADDR_IRQ_EN, 32'hF, 32'hF);
    wb(1'b1, cfg_pins_pkg::ADDR_CTRL, 32'h2, 32'h0);
    foreach (modes[i]) begin
      mode_q <= modes[i];
      clear_req_n_i <= 1'b0;
      repeat (150) @(posedge clk_i);
      chk(z(clear_done_n_o), 32'h0);
      chk(z(done_oe_o), 32'h1);
      clear_req_n_i <= 1'b1;
      repeat (64) @(posedge clk_i);
      chk(z(clear_done_n_o), 32'h0);
      wait_lvl(clear_done_n_o, 1'b1, 80);
      repeat (4) @(posedge clk_i);
      if (modes[i] == 3'h4) begin
        wait_lvl(addr_strobe_o, 1'b1, 400);
        chk(32'(prom_addr_o), 32'h0);
        repeat (40) @(posedge clk_i);
        chk(32'(prom_addr_o), 32'h1);
      end
      if (modes[i] == 3'h6) chk(32'(prom_addr_o), 32'(cfg_pins_pkg::ADDR_TOP));
      if (modes[i] == 3'h0) begin
        wait_lvl(config_clock_o, 1'b1, 40);
        repeat (int'(cfg_pins_pkg::SLOW_HALF)) @(posedge clk_i);
        chk(z(config_clock_o), 32'h0);
        repeat (int'(cfg_pins_pkg::SLOW_HALF)) @(posedge clk_i);
        chk(z(config_clock_o), 32'h1);
      end
      wb(1'b0, cfg_pins_pkg::ADDR_STATUS, 32'({modes[i], 14'h0}), 32'h1C000);
      if (modes[i] inside {3'h1, 3'h2}) begin
        wb(1'b0, cfg_pins_pkg::ADDR_IRQ_ST, 32'h8, 32'h8);
        wb(1'b1, cfg_pins_pkg::ADDR_IRQ_CLR, 32'h8, 32'h0);
      end else begin
        chk(z(config_clock_oe_o), z(modes[i] inside {3'h0, 3'h4, 3'h5, 3'h6}));
      end
      if (modes[i] == 3'h5) begin
        host_sel_i  <= 1'b1;
        host_wr_n_i <= 1'b0;
        wait_lvl(byte_ready_o, 1'b0, 10);
        host_wr_n_i <= 1'b1;
        host_rd_n_i <= 1'b0;
        wait_lvl(data_msb_oe_o, 1'b1, 10);
        chk(z(data_msb_o), 32'h0);
        host_sel_i  <= 1'b0;
        host_rd_n_i <= 1'b1;
        wait_lvl(byte_ready_o, 1'b1, 200);
      end
    end
    // Slave serial load while the completion line is held low outside
    done_hold_n <= 1'b0;
    run <= 1'b1;
    wait_lvl(done_oe_o, 1'b0, 600);
    wait_lvl(config_clock_i, 1'b1, 20);
    b = din_i;
    wait_lvl(config_clock_i, 1'b0, 20);
    repeat (6) @(posedge clk_i);
    chk(z(dout_o), z(b));
    run <= 1'b0;
    repeat (20) @(posedge clk_i);
    chk(z(startup_o), 32'h0);
    done_hold_n <= 1'b1;
    wait_lvl(startup_o, 1'b1, 20);
    chk(z(readback_clk_en_o), 32'h1);
    wb(1'b0, cfg_pins_pkg::ADDR_IRQ_ST, 32'h2, 32'h2);
    chk(z(irq_o), 32'h1);
    wb(1'b1, cfg_pins_pkg::ADDR_IRQ_CLR, 32'hF, 32'h0);
    repeat (2) @(posedge clk_i);
    chk(z(irq_o), 32'h0);
    wb(1'b0, cfg_pins_pkg::ADDR_IRQ_ST, 32'h0, 32'h2);
    wb(1'b1, cfg_pins_pkg::ADDR_CTRL, 32'h78, 32'h0);
    repeat (2) @(posedge clk_i);
    chk({30'h0, mode_select_1_o, mode_select_1_oe_o}, 32'h3);
    chk({30'h0, tdo_o, tdo_oe_o}, 32'h3);
    wb(1'b1, cfg_pins_pkg::ADDR_CTRL, 32'h4, 32'h0);
    scan_tdo_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk(z(tdo_o), 32'h1);
    scan_tdo_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(z(tdo_o), 32'h0);
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
